//--- verilog/rpms_consts.vh
/*
 * holds: register offsets, field positions, reset values and timing figures
 *        of the reader power mode sequencer.
 * assumes: included by bare name; clock of 10 MHz (100 ns period).
 */
`ifndef RPMS_CONSTS_VH
`define RPMS_CONSTS_VH

// ****************************************************
// register byte addresses
// ****************************************************
`define RPMS_ADDR_CSC        8'h00
`define RPMS_ADDR_REG        8'h2C
`define RPMS_ADDR_OSC        8'h3C
`define RPMS_ADDR_STATE      8'h40
// ****************************************************
// register indices (printed offsets)
// ****************************************************
`define RPMS_IDX_CSC         8'h00
`define RPMS_IDX_REG         8'h0B
`define RPMS_IDX_OSC         8'h0F
// ****************************************************
// field positions
// ****************************************************
`define RPMS_CSC_STBY        7
`define RPMS_CSC_TXALL       5
`define RPMS_CSC_HALF        4
`define RPMS_CSC_RXON        1
`define RPMS_CSC_5V          0
`define RPMS_REG_AUTO        7
`define RPMS_OSC_OK          6
// ****************************************************
// reset values
// ****************************************************
`define RPMS_CSC_RESET       8'h01
`define RPMS_REG_RESET       8'h87
// ****************************************************
// timing figures
// ****************************************************
`define RPMS_CLK_HZ          10000000
`define RPMS_CONFIRM_US      100
`define RPMS_STBY_US         100
`define RPMS_MODE1_US        25
`define RPMS_AUX_HZ          60000
`define RPMS_SETTLE_US       500
`define RPMS_ADJ_US          50

`endif

//--- verilog/rpms_timer.v
/*
 * holds: a loadable down counter that flags when it reaches zero.
 * assumes: single clock clk_i, synchronous active-high reset.
 */
`timescale 1ns/100ps

module rpms_timer #(
    parameter W = 16
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // control
    input  wire         load_i,
    input  wire [W-1:0] value_i,
    // status
    output wire         done_o
);

    reg [W-1:0] count;

    always @(posedge clk_i) begin
        if (rst_i) begin
            count <= {W{1'b0}};
        end else if (load_i) begin
            count <= value_i;
        end else if (count != {W{1'b0}}) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done_o = (count == {W{1'b0}});

endmodule // rpms_timer

//--- verilog/rpms_sequencer.v
/*
 * holds: power mode sequencer with a classic Wishbone register slave.
 * assumes: clk_i is the crystal-derived clock at 10 MHz; enable pins are
 *          asynchronous and pass three flip-flops; rst_i synchronous.
 */
`timescale 1ns/100ps
`include "rpms_consts.vh"


module rpms_sequencer #(
    parameter SETTLE_CYC = (`RPMS_SETTLE_US * (`RPMS_CLK_HZ / 1000000)),
    parameter TW         = 16
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg         err_o,
    // enable pins
    input  wire        main_enable_i,
    input  wire        wake_enable_pin_i,
    // power controls
    output reg         digital_supply_output_o,
    output reg         regulators_on_o,
    output reg         osc_run_o,
    output reg         regulator_adjust_o,
    output reg         tx_on_o,
    output reg         tx_half_o,
    output reg         rx_on_o,
    output reg         supply_5v_o,
    // controller clock output
    output reg         controller_clock_output_o,
    output reg         clock_fast_o
);

    // ****************************************************
    // timing counts
    // ****************************************************
    localparam CYC_PER_US  = `RPMS_CLK_HZ / 1000000;
    localparam CONFIRM_CYC = `RPMS_CONFIRM_US * CYC_PER_US;
    localparam STBY_CYC    = `RPMS_STBY_US * CYC_PER_US;
    localparam MODE1_CYC   = `RPMS_MODE1_US * CYC_PER_US;
    localparam ADJ_CYC     = `RPMS_ADJ_US * CYC_PER_US;
    localparam AUX_HALF    = `RPMS_CLK_HZ / (2 * `RPMS_AUX_HZ);

    // ****************************************************
    // states
    // ****************************************************
    localparam ST_DOWN    = 3'd0;
    localparam ST_SLEEP   = 3'd1;
    localparam ST_START   = 3'd2;
    localparam ST_CONFIRM = 3'd3;
    localparam ST_RESUME  = 3'd4;
    localparam ST_ACTIVE  = 3'd5;

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    reg [2:0] en_sync;
    reg [2:0] wake_sync;
    reg       en_lvl;
    reg       wake_lvl;
    reg       en_prev;
    reg       wake_prev;

    always @(posedge clk_i) begin
        if (rst_i) begin
            en_sync   <= 3'h0;
            wake_sync <= 3'h0;
            en_lvl    <= 1'b0;
            wake_lvl  <= 1'b0;
            en_prev   <= 1'b0;
            wake_prev <= 1'b0;
        end else begin
            en_sync   <= {en_sync[1:0], main_enable_i};
            wake_sync <= {wake_sync[1:0], wake_enable_pin_i};
            if (en_sync[1] == en_sync[2]) begin
                en_lvl <= en_sync[2];
            end
            if (wake_sync[1] == wake_sync[2]) begin
                wake_lvl <= wake_sync[2];
            end
            en_prev   <= en_lvl;
            wake_prev <= wake_lvl;
        end
    end

    wire en_rise   = en_lvl & ~en_prev;
    wire wake_rise = wake_lvl & ~wake_prev;

    // ****************************************************
    // registers
    // ****************************************************
    reg  [7:0] csc;
    reg  [7:0] regctl;
    reg        osc_ok;
    reg  [2:0] state;
    reg  [2:0] next_state;
    reg        csc_prev_stby;

    wire       bus_req = cyc_i & stb_i & ~ack_o & ~err_o;
    wire       hit_csc = (adr_i == `RPMS_ADDR_CSC);
    wire       hit_reg = (adr_i == `RPMS_ADDR_REG);
    wire       hit_osc = (adr_i == `RPMS_ADDR_OSC);
    wire       hit_st  = (adr_i == `RPMS_ADDR_STATE);
    wire       hit_any = hit_csc | hit_reg | hit_osc | hit_st;
    wire       wr_go   = cyc_i & stb_i & we_i & sel_i[0] & ack_o;
    wire       wr_reg  = wr_go & hit_reg;
    wire       auto_rise = wr_reg & dat_i[`RPMS_REG_AUTO] & ~regctl[`RPMS_REG_AUTO];

    always @(posedge clk_i) begin
        if (rst_i) begin
            csc    <= `RPMS_CSC_RESET;
            regctl <= `RPMS_REG_RESET;
            ack_o  <= 1'b0;
            err_o  <= 1'b0;
            dat_o  <= 32'h00000000;
        end else begin
            ack_o <= bus_req & hit_any;
            err_o <= bus_req & ~hit_any;
            if (wr_go & hit_csc) begin
                csc <= dat_i[7:0];
            end
            if (wr_reg) begin
                regctl <= dat_i[7:0];
            end
            if (bus_req & ~we_i) begin
                dat_o <= 32'h00000000;
                if (hit_csc) begin
                    dat_o[7:0] <= csc;
                end
                if (hit_reg) begin
                    dat_o[7:0] <= regctl;
                end
                if (hit_osc) begin
                    dat_o[`RPMS_OSC_OK] <= osc_ok;
                end
                if (hit_st) begin
                    dat_o[2:0] <= state;
                end
            end
        end
    end

    // ****************************************************
    // timers
    // ****************************************************
    reg             t_load;
    reg  [TW-1:0]   t_value;
    wire            t_done;
    reg             a_load;
    wire            a_done;

    rpms_timer #(
        .W (TW)
    ) u_seq_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (t_load),
        .value_i (t_value),
        .done_o  (t_done)
    );

    rpms_timer #(
        .W (TW)
    ) u_adj_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (a_load),
        .value_i (ADJ_CYC[TW-1:0]),
        .done_o  (a_done)
    );

    // ****************************************************
    // state machine
    // ****************************************************
    always @* begin
        next_state = state;
        t_load     = 1'b0;
        t_value    = SETTLE_CYC[TW-1:0];
        case (state)
            ST_DOWN, ST_SLEEP: begin
                if (en_lvl | wake_rise) begin
                    next_state = ST_START;
                    t_load     = 1'b1;
                end else if (wake_lvl) begin
                    next_state = ST_SLEEP;
                end else begin
                    next_state = ST_DOWN;
                end
            end
            ST_START: begin
                if (t_done & a_done) begin
                    t_load     = 1'b1;
                    t_value    = CONFIRM_CYC[TW-1:0];
                    next_state = en_lvl ? ST_ACTIVE : ST_CONFIRM;
                end
            end
            ST_CONFIRM: begin
                if (en_lvl) begin
                    next_state = ST_ACTIVE;
                end else if (t_done) begin
                    next_state = wake_lvl ? ST_SLEEP : ST_DOWN;
                end
            end
            ST_RESUME: begin
                if (~en_lvl) begin
                    next_state = wake_lvl ? ST_SLEEP : ST_DOWN;
                end else if (t_done) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (~en_lvl) begin
                    next_state = wake_lvl ? ST_SLEEP : ST_DOWN;
                end else if (csc_prev_stby & ~csc[`RPMS_CSC_STBY]) begin
                    next_state = ST_RESUME;
                    t_load     = 1'b1;
                    t_value    = STBY_CYC[TW-1:0];
                end
            end
            default: begin
                next_state = ST_DOWN;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state         <= ST_DOWN;
            osc_ok        <= 1'b0;
            csc_prev_stby <= 1'b0;
            a_load        <= 1'b0;
        end else begin
            state         <= next_state;
            csc_prev_stby <= csc[`RPMS_CSC_STBY];
            a_load        <= (en_rise | auto_rise) & regctl[`RPMS_REG_AUTO] | auto_rise;
            if ((state == ST_START) && (next_state != ST_START)) begin
                osc_ok <= 1'b1;
            end else if ((next_state == ST_DOWN) || (next_state == ST_SLEEP)) begin
                osc_ok <= 1'b0;
            end
        end
    end

    // ****************************************************
    // mode 1 resume delay
    // ****************************************************
    reg [TW-1:0] m1_count;
    reg          m1_ready;

    always @(posedge clk_i) begin
        if (rst_i) begin
            m1_count <= {TW{1'b0}};
            m1_ready <= 1'b0;
        end else if (state != ST_ACTIVE || csc[`RPMS_CSC_STBY]) begin
            m1_count <= MODE1_CYC[TW-1:0];
            m1_ready <= 1'b0;
        end else if (m1_count != {TW{1'b0}}) begin
            m1_count <= m1_count - {{(TW-1){1'b0}}, 1'b1};
        end else begin
            m1_ready <= 1'b1;
        end
    end

    // ****************************************************
    // auxiliary clock divider
    // ****************************************************
    reg [TW-1:0] aux_count;
    reg          aux_clk;

    always @(posedge clk_i) begin
        if (rst_i) begin
            aux_count <= {TW{1'b0}};
            aux_clk   <= 1'b0;
        end else if (aux_count == AUX_HALF[TW-1:0] - {{(TW-1){1'b0}}, 1'b1}) begin
            aux_count <= {TW{1'b0}};
            aux_clk   <= ~aux_clk;
        end else begin
            aux_count <= aux_count + {{(TW-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    wire running = (state == ST_ACTIVE) || (state == ST_RESUME);
    wire rf_ok   = (state == ST_ACTIVE) & ~csc[`RPMS_CSC_STBY] & m1_ready;

    always @(posedge clk_i) begin
        if (rst_i) begin
            digital_supply_output_o   <= 1'b0;
            regulators_on_o           <= 1'b0;
            osc_run_o                 <= 1'b0;
            regulator_adjust_o        <= 1'b0;
            tx_on_o                   <= 1'b0;
            tx_half_o                 <= 1'b0;
            rx_on_o                   <= 1'b0;
            supply_5v_o               <= 1'b1;
            controller_clock_output_o <= 1'b0;
            clock_fast_o              <= 1'b0;
        end else begin
            digital_supply_output_o <= (state != ST_DOWN);
            regulators_on_o         <= (state != ST_DOWN) && (state != ST_SLEEP);
            osc_run_o               <= (state != ST_DOWN) && (state != ST_SLEEP);
            regulator_adjust_o      <= ~a_done;
            supply_5v_o             <= csc[`RPMS_CSC_5V];
            tx_on_o                 <= rf_ok & csc[`RPMS_CSC_TXALL];
            tx_half_o               <= rf_ok & csc[`RPMS_CSC_TXALL] & csc[`RPMS_CSC_HALF];
            rx_on_o                 <= rf_ok & (csc[`RPMS_CSC_TXALL] | csc[`RPMS_CSC_RXON]);
            clock_fast_o            <= running || (state == ST_CONFIRM);
            if (running || (state == ST_CONFIRM)) begin
                controller_clock_output_o <= ~controller_clock_output_o;
            end else if (state == ST_DOWN) begin
                controller_clock_output_o <= 1'b0;
            end else begin
                controller_clock_output_o <= aux_clk;
            end
        end
    end

endmodule // rpms_sequencer

//--- testbench/rpms_sequencer_assertions.sv
/* holds: port checks for the power mode sequencer.
   assumes: bound to rpms_sequencer; one clock, rst_i synchronous. */
`timescale 1ns/100ps
`include "rpms_consts.vh"
module rpms_sequencer_assertions #(
    parameter SETTLE_CYC = 20
) (
    // clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        err_o,
    // pins and power controls
    input wire logic        main_enable_i,
    input wire logic        wake_enable_pin_i,
    input wire logic        digital_supply_output_o,
    input wire logic        regulators_on_o,
    input wire logic        osc_run_o,
    input wire logic        regulator_adjust_o,
    input wire logic        tx_on_o,
    input wire logic        tx_half_o,
    input wire logic        rx_on_o,
    input wire logic        supply_5v_o,
    input wire logic        controller_clock_output_o,
    input wire logic        clock_fast_o
);
    logic       prev_clk;
    logic [7:0] hold_cnt;
    // ********************************
    // aux clock level hold counter
    // ********************************
    always @(posedge clk_i) begin
        prev_clk <= controller_clock_output_o;
        if (rst_i || clock_fast_o || !digital_supply_output_o
            || controller_clock_output_o != prev_clk) begin
            hold_cnt <= 8'h00;
        end else if (hold_cnt != 8'hFF) begin
            hold_cnt <= hold_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    pd_all_off_a: assert property (
        !digital_supply_output_o |-> !(tx_on_o || rx_on_o || osc_run_o || clock_fast_o
        || controller_clock_output_o)) else $error("output on in power-down");
    aux_half_period_a: assert property (hold_cnt < 8'h55)
        else $error("aux clock half period too long");
    fast_needs_osc_a: assert property (
        clock_fast_o |-> regulators_on_o && osc_run_o && digital_supply_output_o)
        else $error("fast clock without supplies");
    settle_first_a: assert property (
        $rose(clock_fast_o) |-> $past(osc_run_o, SETTLE_CYC)) else $error("start-up too short");
    rf_needs_fast_a: assert property ((tx_on_o || rx_on_o) |-> clock_fast_o)
        else $error("rf on outside active");
    tx_with_rx_a: assert property ((tx_on_o || tx_half_o) |-> tx_on_o && rx_on_o)
        else $error("transmitter without receiver");
    supply_sel_a: assert property (
        $changed(supply_5v_o) |-> $past(ack_o && we_i) || $past(ack_o && we_i, 2))
        else $error("supply select changed without write");
    bus_answer_a: assert property (
        cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o) else $error("no bus answer");
    bus_pulse_a: assert property ((ack_o || err_o) |=> !(ack_o || err_o))
        else $error("bus answer longer than one cycle");
    start_seen_c: cover property ($rose(clock_fast_o));
    sleep_seen_c: cover property (digital_supply_output_o && !regulators_on_o);
    half_seen_c: cover property (tx_half_o);
endmodule // rpms_sequencer_assertions
bind rpms_sequencer rpms_sequencer_assertions #(.SETTLE_CYC(SETTLE_CYC)) chk_u (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
    .main_enable_i, .wake_enable_pin_i, .digital_supply_output_o, .regulators_on_o,
    .osc_run_o, .regulator_adjust_o, .tx_on_o, .tx_half_o, .rx_on_o, .supply_5v_o,
    .controller_clock_output_o, .clock_fast_o);

//--- testbench/rpms_mcu_model.sv
/* holds: controller model driving the two enable pins.
   assumes: clk_i is the bench clock; GAP counted in its cycles. */
`timescale 1ns/100ps
module rpms_mcu_model #(
    parameter int GAP = 10000
) (
    // clock and requested levels
    input  wire logic clk_i,
    input  wire logic want_main_i,
    input  wire logic want_wake_i,
    // enable pins
    output logic      main_enable_o,
    output logic      wake_enable_o
);
    int since_main = GAP;
    int since_wake = GAP;
    initial begin
        main_enable_o = 1'b0;
        wake_enable_o = 1'b0;
    end
    // ********************************
    // one pin at a time, spaced apart
    // ********************************
    always @(posedge clk_i) begin
        since_main <= since_main + 1;
        since_wake <= since_wake + 1;
        if (want_main_i != main_enable_o && since_wake >= GAP) begin
            main_enable_o <= want_main_i;
            since_main <= 0;
        end else if (want_wake_i != wake_enable_o && since_main >= GAP) begin
            wake_enable_o <= want_wake_i;
            since_wake <= 0;
        end
    end
endmodule // rpms_mcu_model

//--- testbench/tb_reader_power_mode_sequencer.sv
/* holds: self-checking bench for the power mode sequencer.
   assumes: rpms_sequencer, checker and controller model compiled first. */
`timescale 1ns/100ps
`include "rpms_consts.vh"
module tb_reader_power_mode_sequencer;
    localparam int LIMIT = 80000;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic        want_main = 1'b0;
    logic        want_wake = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o, err_o, main_enable_i, wake_enable_pin_i, regulator_adjust_o;
    logic        digital_supply_output_o, regulators_on_o, osc_run_o, clock_fast_o;
    logic        tx_on_o, tx_half_o, rx_on_o, supply_5v_o, controller_clock_output_o;
    logic [7:0]  rd;
    logic [7:0]  csc_m = 8'h01;
    logic        er, sb;
    int          mismatches = 0, n_compared = 0, cyc_cnt = 0, adj_cnt = 0, a0, k;
    int          csc_t[$] = '{8'h80, 8'h00, 8'h02, 8'h30, 8'h20, 8'h81, 8'h01, 8'h03, 8'h31, 8'h21};
    int          reg_t[$] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07};
    wire logic [7:0] pins = {digital_supply_output_o, regulators_on_o, osc_run_o, clock_fast_o,
                             tx_on_o, tx_half_o, rx_on_o, supply_5v_o};
    rpms_sequencer #(.SETTLE_CYC(20)) dut_u (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'h1), .dat_i, .dat_o, .ack_o,
        .err_o, .main_enable_i, .wake_enable_pin_i, .digital_supply_output_o, .regulators_on_o,
        .osc_run_o, .regulator_adjust_o, .tx_on_o, .tx_half_o, .rx_on_o, .supply_5v_o,
        .controller_clock_output_o, .clock_fast_o);
    rpms_mcu_model #(.GAP(10000)) mcu_u (.clk_i, .want_main_i(want_main), .want_wake_i(want_wake),
        .main_enable_o(main_enable_i), .wake_enable_o(wake_enable_pin_i));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (regulator_adjust_o === 1'b1) adj_cnt++;
        if (cyc_cnt == LIMIT) begin
            mismatches++;
            print_verdict;
        end
    end
    // ********************************
    // compare, bus and wait tasks
    // ********************************
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic [3:0] pw);
        logic on;
        on = pw[0] && !csc_m[7];
        cmp_reg(pins, {pw, on && csc_m[5], on && csc_m[5] && csc_m[4],
                       on && (csc_m[5] || csc_m[1]), csc_m[0]});
    endtask
    task automatic cmp_clk(input int n, input int exp);
        int t;
        logic p;
        t = 0;
        p = controller_clock_output_o;
        repeat (n) begin
            @(posedge clk_i);
            if (controller_clock_output_o !== p) t++;
            p = controller_clock_output_o;
        end
        cmp_reg(t[7:0], exp[7:0]);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        r = $urandom();
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {r[31:8], d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o[7:0];
        er = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wait_fast;
        for (int i = 0; i < 20000 && clock_fast_o !== 1'b1; i++) @(posedge clk_i);
    endtask
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        void'($urandom(32'h8C1CCC54));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `RPMS_ADDR_CSC, 8'h00);
        cmp_reg(rd, 8'h01);
        wb(1'b0, `RPMS_ADDR_REG, 8'h00);
        cmp_reg(rd, 8'h87);
        wb(1'b0, 8'h10, 8'h00);
        cmp_reg({7'h00, er}, 8'h01);
        cmp_pin(4'h0);
        want_wake <= 1'b1;
        repeat (8) @(posedge clk_i);
        cmp_pin(4'hE);
        wait_fast;
        wb(1'b0, `RPMS_ADDR_OSC, 8'h00);
        cmp_reg(rd & 8'h40, 8'h40);
        cmp_pin(4'hF);
        repeat (800) @(posedge clk_i);
        cmp_pin(4'hF);
        repeat (300) @(posedge clk_i);
        cmp_pin(4'h8);
        cmp_clk(830, 830 / (`RPMS_CLK_HZ / (2 * `RPMS_AUX_HZ)));
        wb(1'b0, `RPMS_ADDR_OSC, 8'h00);
        cmp_reg(rd & 8'h40, 8'h00);
        repeat (200) @(posedge clk_i);
        want_wake <= 1'b0;
        repeat (8) @(posedge clk_i);
        cmp_pin(4'h0);
        cmp_clk(100, 0);
        a0 = adj_cnt;
        want_main <= 1'b1;
        wait_fast;
        cmp_reg({7'h00, adj_cnt > a0}, 8'h01);
        cmp_pin(4'hF);
        repeat (1200) @(posedge clk_i);
        cmp_pin(4'hF);
        for (int i = 0; i < 16; i++) begin
            k = (i < 10) ? i : $urandom % 10;
            sb = csc_m[7];
            wb(1'b1, `RPMS_ADDR_REG, reg_t[k][7:0]);
            wb(1'b0, `RPMS_ADDR_REG, 8'h00);
            cmp_reg(rd, reg_t[k][7:0]);
            wb(1'b1, `RPMS_ADDR_CSC, csc_t[k][7:0]);
            csc_m = csc_t[k][7:0];
            repeat (sb ? 1270 : 270) @(posedge clk_i);
            wb(1'b0, `RPMS_ADDR_CSC, 8'h00);
            cmp_reg(rd, csc_m);
            cmp_pin(4'hF);
        end
        a0 = adj_cnt;
        wb(1'b1, `RPMS_ADDR_REG, 8'h07);
        wb(1'b1, `RPMS_ADDR_REG, 8'h87);
        repeat (4) @(posedge clk_i);
        cmp_reg({7'h00, adj_cnt > a0}, 8'h01);
        wb(1'b1, `RPMS_ADDR_OSC, 8'h00);
        wb(1'b0, `RPMS_ADDR_OSC, 8'h00);
        cmp_reg(rd & 8'h40, 8'h40);
        want_main <= 1'b0;
        repeat (100) @(posedge clk_i);
        cmp_pin(4'h0);
        print_verdict;
    end
endmodule // tb_reader_power_mode_sequencer
